/* File: chan2_cfg_regs.sv */
/*
  Channel two configuration register bank with AHB-Lite slave port,
  plus the sample-aligned volume and fine gain stage controls.
  Assumes a single bus master, word transfers, and a sample strobe
  from logic on clk_sys.
*/
// Register access over AHB-Lite was chosen for this implementation.
// Contract
// R01 - Bits 7-6 select differential or single-ended input
// R02 - Software writes only the two usable source codes
// R03 - Software writes reserved bits 5-4 as zero
// R04 - Bits 3-2 select common-mode tolerance
// R05 - Bit 1 selects 10 or 5 Vrms
// R06 - Bit 0 selects 24 or 96 kHz bandwidth
// R07 - Wide bandwidth only with 40 kilohm input
// R08 - Volume code zero mutes the channel
// R09 - Volume codes step half decibel around 161
// R10 - Volume register at 0x57, resets 0xA1
// R11 - Fine gain bits 7-4, 0.1 dB steps
// R12 - Fine gain bits 3-0 read zero
// R13 - Fine gain register at 0x58, resets 0x80
// R14 - Input register at 0x55, resets 0x00
// R15 - Gain changes apply from next sample
`timescale 1ns/1ps
module chan2_cfg_regs
  import chan2_cfg_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  // Analog front end controls
  output logic [1:0]                      chan2_input_source,
  output logic [1:0]                      chan2_common_mode_tolerance,
  output logic                            chan2_full_scale_select,
  output logic                            chan2_bandwidth_select,
  // Digital volume and gain stage
  output logic [7:0]                      chan2_volume_code,
  output logic [3:0]                      chan2_fine_gain_code,
  output logic                            chan2_mute,
  output logic signed [8:0]               volume_half_db,
  output logic signed [4:0]               fine_gain_tenth_db,
  // Sample path
  input  wire logic                       sample_in_valid,
  input  wire logic [SAMPLE_W-1:0]        sample_in,
  output logic                            sample_out_valid,
  output logic [SAMPLE_W-1:0]             sample_out
);

  // A zero-width sample bus has nothing to mute
  if (SAMPLE_W < 1) begin : g_width_check
    $error("SAMPLE_W must be at least 1");
  end

  typedef struct packed {
    logic [7:0]          cfg0;
    logic [7:0]          vol;
    logic [3:0]          fgain;
    logic                wr_pend;
    logic [1:0]          wr_sel;
    logic [31:0]         rdata;
    logic [7:0]          act_vol;
    logic [3:0]          act_fg;
    logic signed [8:0]   vol_hdb;
    logic signed [4:0]   fg_tdb;
    logic                mute;
    logic                out_valid;
    logic [SAMPLE_W-1:0] out_sample;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [1:0] addr_sel;

  // Full word-index compare so aliases above the map stay unmapped
  function automatic logic [1:0] decode_sel(input logic [31:0] addr);
    logic [1:0] sel;
    sel = SEL_NONE;
    if (addr[31:2] == CHAN2_INPUT_CONFIG_IDX) begin
      sel = SEL_CFG0;
    end else if (addr[31:2] == CHAN2_VOLUME_IDX) begin
      sel = SEL_VOL;
    end else if (addr[31:2] == CHAN2_FINE_GAIN_IDX) begin
      sel = SEL_FG;
    end
    return sel;
  endfunction : decode_sel

  always_comb begin
    st_d = st_q;
    addr_sel = decode_sel(haddr);
    st_d.wr_pend = 1'b0;
    // Data phase of a write lands here
    if (st_q.wr_pend) begin
      case (st_q.wr_sel)
        SEL_CFG0: begin
          st_d.cfg0 = hwdata[7:0]; // R01 R04 R05 R06
        end
        SEL_VOL: begin
          st_d.vol = hwdata[7:0]; // R08
        end
        SEL_FG: begin
          st_d.fgain = hwdata[FG_MSB:FG_LSB]; // R11
        end
        default: begin
        end
      endcase
    end
    // Address phase; read data built from st_d so a read right after
    // a write to the same register returns the new value
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        st_d.wr_pend = (addr_sel != SEL_NONE);
        st_d.wr_sel  = addr_sel;
      end else begin
        case (addr_sel)
          SEL_CFG0: begin
            st_d.rdata = {24'h000000, st_d.cfg0};
          end
          SEL_VOL: begin
            st_d.rdata = {24'h000000, st_d.vol};
          end
          SEL_FG: begin
            st_d.rdata = {24'h000000, st_d.fgain, 4'h0}; // R12
          end
          default: begin
            st_d.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
    // Gain codes move only on a sample boundary, never mid-sample
    st_d.out_valid = sample_in_valid;
    if (sample_in_valid) begin
      st_d.act_vol = st_q.vol; // R15
      st_d.act_fg  = st_q.fgain; // R15
      st_d.vol_hdb = $signed({1'b0, st_q.vol} - VOL_UNITY_CODE); // R09
      st_d.fg_tdb  = $signed({1'b0, st_q.fgain} - FG_UNITY_CODE); // R11
      st_d.mute    = (st_q.vol == VOL_MUTE_CODE); // R08
      if (st_q.vol == VOL_MUTE_CODE) begin
        st_d.out_sample = '0; // R08
      end else begin
        st_d.out_sample = sample_in;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q.cfg0       <= CHAN2_INPUT_CONFIG_RST; // R14
      st_q.vol        <= CHAN2_VOLUME_RST; // R10
      st_q.fgain      <= CHAN2_FINE_GAIN_RST[FG_MSB:FG_LSB]; // R13
      st_q.wr_pend    <= 1'b0;
      st_q.wr_sel     <= SEL_NONE;
      st_q.rdata      <= 32'h0000_0000;
      st_q.act_vol    <= CHAN2_VOLUME_RST;
      st_q.act_fg     <= CHAN2_FINE_GAIN_RST[FG_MSB:FG_LSB];
      st_q.vol_hdb    <= 9'sh000;
      st_q.fg_tdb     <= 5'sh00;
      st_q.mute       <= 1'b0;
      st_q.out_valid  <= 1'b0;
      st_q.out_sample <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_q.rdata;

  assign chan2_input_source          = st_q.cfg0[SRC_MSB:SRC_LSB]; // R01
  assign chan2_common_mode_tolerance = st_q.cfg0[CMT_MSB:CMT_LSB]; // R04
  assign chan2_full_scale_select     = st_q.cfg0[FS_BIT]; // R05
  assign chan2_bandwidth_select      = st_q.cfg0[BW_BIT]; // R06
  assign chan2_volume_code           = st_q.act_vol;
  assign chan2_fine_gain_code        = st_q.act_fg;
  assign chan2_mute                  = st_q.mute;
  assign volume_half_db              = st_q.vol_hdb;
  assign fine_gain_tenth_db          = st_q.fg_tdb;
  assign sample_out_valid            = st_q.out_valid;
  assign sample_out                  = st_q.out_sample;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic rd_fg;
  logic wr_cfg0;
  assign rd_fg   = hsel && hready && htrans[1] && !hwrite && (addr_sel == SEL_FG);
  assign wr_cfg0 = st_q.wr_pend && (st_q.wr_sel == SEL_CFG0);

  // Address phases taken and data phases landing, per register
  logic wr_vol;
  logic wr_fg;
  logic wr_addr;
  logic rd_addr;
  assign wr_vol  = st_q.wr_pend && (st_q.wr_sel == SEL_VOL);
  assign wr_fg   = st_q.wr_pend && (st_q.wr_sel == SEL_FG);
  assign wr_addr = hsel && hready && htrans[1] && hwrite;
  assign rd_addr = hsel && hready && htrans[1] && !hwrite;

  property p_src_write;
    wr_cfg0 |=> chan2_input_source == $past(hwdata[SRC_MSB:SRC_LSB]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source field not written"); // R01

  property p_cmt_write;
    wr_cfg0 |=> chan2_common_mode_tolerance == $past(hwdata[CMT_MSB:CMT_LSB]);
  endproperty
  a_cmt_write: assert property (p_cmt_write) else $error("tolerance field not written"); // R04

  property p_fs_write;
    wr_cfg0 |=> chan2_full_scale_select == $past(hwdata[FS_BIT]);
  endproperty
  a_fs_write: assert property (p_fs_write) else $error("full scale bit not written"); // R05

  property p_bw_hold;
    !wr_cfg0 |=> $stable(chan2_bandwidth_select);
  endproperty
  a_bw_hold: assert property (p_bw_hold) else $error("bandwidth bit moved"); // R06

  property p_mute_sample;
    (sample_in_valid && st_q.vol == VOL_MUTE_CODE)
      |=> chan2_mute && sample_out_valid && (sample_out == '0);
  endproperty
  a_mute_sample: assert property (p_mute_sample) else $error("mute not applied"); // R08

  property p_vol_map;
    (sample_in_valid && st_q.vol == CHAN2_VOLUME_RST)
      |=> (volume_half_db == 9'sh000) && !chan2_mute;
  endproperty
  a_vol_map: assert property (p_vol_map) else $error("unity code not 0 dB"); // R09

  property p_fg_map;
    (sample_in_valid && st_q.fgain == 4'h0) |=> fine_gain_tenth_db == -5'sd8;
  endproperty
  a_fg_map: assert property (p_fg_map) else $error("fine gain code 0 wrong"); // R11

  property p_fg_low_zero;
    rd_fg |=> (hrdata[3:0] == 4'h0) && (hrdata[31:8] == 24'h000000);
  endproperty
  a_fg_low_zero: assert property (p_fg_low_zero) else $error("reserved bits nonzero"); // R12

  property p_reset_vals;
    $rose(rst_n) |-> (st_q.vol == CHAN2_VOLUME_RST)
      && (st_q.fgain == CHAN2_FINE_GAIN_RST[FG_MSB:FG_LSB])
      && (st_q.cfg0 == CHAN2_INPUT_CONFIG_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // R10 R13 R14

  property p_sample_aligned;
    !sample_in_valid |=> $stable(chan2_volume_code) && $stable(chan2_fine_gain_code);
  endproperty
  a_sample_aligned: assert property (p_sample_aligned) else $error("gain moved off sample"); // R15

  property p_bw_write;
    wr_cfg0 |=> chan2_bandwidth_select == $past(hwdata[BW_BIT]);
  endproperty
  a_bw_write: assert property (p_bw_write) else $error("bandwidth bit not written"); // R06

  property p_cfg_hold;
    !wr_cfg0 |=> $stable(chan2_input_source) && $stable(chan2_common_mode_tolerance)
      && $stable(chan2_full_scale_select);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("input config moved"); // R01 R04 R05

  property p_vol_write;
    wr_vol |=> st_q.vol == $past(hwdata[7:0]);
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("volume not written"); // R08

  property p_fg_write;
    wr_fg |=> st_q.fgain == $past(hwdata[FG_MSB:FG_LSB]);
  endproperty
  a_fg_write: assert property (p_fg_write) else $error("fine gain not written"); // R11

  // Each byte address must reach its own register and no other
  property p_addr_cfg0;
    (wr_addr && haddr == {CHAN2_INPUT_CONFIG_IDX, 2'b00}) |=> wr_cfg0;
  endproperty
  a_addr_cfg0: assert property (p_addr_cfg0) else $error("input register not decoded"); // R14

  property p_addr_vol;
    (wr_addr && haddr == {CHAN2_VOLUME_IDX, 2'b00}) |=> wr_vol;
  endproperty
  a_addr_vol: assert property (p_addr_vol) else $error("volume register not decoded"); // R10

  property p_addr_fg;
    (wr_addr && haddr == {CHAN2_FINE_GAIN_IDX, 2'b00}) |=> wr_fg;
  endproperty
  a_addr_fg: assert property (p_addr_fg) else $error("fine gain register not decoded"); // R13

  property p_hole_read;
    (rd_addr && addr_sel == SEL_NONE) |=> hrdata == 32'h0000_0000;
  endproperty
  a_hole_read: assert property (p_hole_read) else $error("hole read nonzero"); // R10 R13 R14

  // Code 1 is -80 dB and code 255 is +47 dB, in half-dB steps
  property p_vol_min;
    (sample_in_valid && st_q.vol == 8'h01)
      |=> (volume_half_db == -9'sh0A0) && !chan2_mute;
  endproperty
  a_vol_min: assert property (p_vol_min) else $error("volume code 1 wrong"); // R09

  property p_vol_max;
    (sample_in_valid && st_q.vol == 8'hFF)
      |=> (volume_half_db == 9'sh05E) && !chan2_mute;
  endproperty
  a_vol_max: assert property (p_vol_max) else $error("volume code 255 wrong"); // R09

  property p_fg_max;
    (sample_in_valid && st_q.fgain == 4'hF) |=> fine_gain_tenth_db == 5'sh07;
  endproperty
  a_fg_max: assert property (p_fg_max) else $error("fine gain code 15 wrong"); // R11

  // Any nonzero code passes the sample on untouched
  property p_pass_through;
    (sample_in_valid && st_q.vol != VOL_MUTE_CODE)
      |=> !chan2_mute && (sample_out == $past(sample_in));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("sample not passed"); // R08

  property p_out_valid;
    sample_out_valid == $past(sample_in_valid);
  endproperty
  a_out_valid: assert property (p_out_valid) else $error("output strobe misplaced"); // R15

  c_write_cfg0: cover property (wr_cfg0);
  c_read_fg: cover property (rd_fg ##1 hrdata[7:4] != 4'h8);
  c_mute: cover property (sample_in_valid && st_q.vol == VOL_MUTE_CODE);
  c_vol_change: cover property (sample_in_valid && st_q.vol != st_q.act_vol);
  c_wide_bw: cover property (wr_cfg0 ##1 chan2_bandwidth_select);

endmodule : chan2_cfg_regs

/* File: chan2_cfg_pkg.sv */
/*
  Register map, field layout and reset values of the channel two
  configuration register bank.
  Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
package chan2_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [29:0] CHAN2_INPUT_CONFIG_IDX = 30'h0000_0055;
  localparam logic [29:0] CHAN2_VOLUME_IDX       = 30'h0000_0057;
  localparam logic [29:0] CHAN2_FINE_GAIN_IDX    = 30'h0000_0058;

  // Reset values
  localparam logic [7:0] CHAN2_INPUT_CONFIG_RST = 8'h00;
  localparam logic [7:0] CHAN2_VOLUME_RST       = 8'hA1;
  localparam logic [7:0] CHAN2_FINE_GAIN_RST    = 8'h80;

  // Field positions
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 6;
  localparam int CMT_MSB = 3;
  localparam int CMT_LSB = 2;
  localparam int FS_BIT  = 1;
  localparam int BW_BIT  = 0;
  localparam int FG_MSB  = 7;
  localparam int FG_LSB  = 4;

  // Field encodings
  localparam logic [1:0] SRC_DIFFERENTIAL  = 2'h0;
  localparam logic [1:0] SRC_SINGLE_ENDED  = 2'h1;
  localparam logic [1:0] CMT_NARROW        = 2'h0;
  localparam logic [1:0] CMT_MEDIUM        = 2'h1;
  localparam logic [1:0] CMT_RAIL_TO_RAIL  = 2'h2;
  localparam logic       FS_10VRMS         = 1'h0;
  localparam logic       FS_5VRMS          = 1'h1;
  localparam logic       BW_AUDIO_24K      = 1'h0;
  localparam logic       BW_WIDE_96K       = 1'h1;
  localparam logic [7:0] VOL_MUTE_CODE     = 8'h00;
  localparam logic [8:0] VOL_UNITY_CODE    = 9'h0A1;
  localparam logic [4:0] FG_UNITY_CODE     = 5'h08;

  // Register select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CFG0 = 2'h1;
  localparam logic [1:0] SEL_VOL  = 2'h2;
  localparam logic [1:0] SEL_FG   = 2'h3;

endpackage : chan2_cfg_pkg

/* File: chan2_cfg_regs_tb.sv */
/*
  Self-checking bench for the channel two configuration register bank.
  Assumes the bank answers with zero wait states and the 24-bit sample path.
*/
`timescale 1ns/1ps
module chan2_cfg_regs_tb;
  import chan2_cfg_pkg::*;

  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = 32'h0;
  logic              hready;
  logic [31:0]       hrdata;
  logic [1:0]        src;
  logic [1:0]        cmt;
  logic              fs;
  logic              bw;
  logic              mute;
  logic              sov;
  logic              resp;
  logic              siv = 1'b0;
  logic [7:0]        vol;
  logic [3:0]        fg;
  logic signed [8:0] vdb;
  logic signed [4:0] fdb;
  logic [23:0]       sin = 24'h0;
  logic [23:0]       sout;
  logic [31:0]       rng = 32'h309C;
  logic [31:0]       rd;
  logic [7:0]        w;
  logic [7:0]        f;
  logic [7:0]        pv = 8'hA1;
  logic [3:0]        pf = 4'h8;
  logic [7:0]        corner [4] = '{8'h00, 8'h01, 8'hA1, 8'hFF};
  int                bad_count = 0;
  int                tests_run = 0;
  int                cycles = 0;

  chan2_cfg_regs i_chan2_cfg_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(resp), .hrdata(hrdata), .chan2_input_source(src), .chan2_common_mode_tolerance(cmt),
    .chan2_full_scale_select(fs), .chan2_bandwidth_select(bw), .chan2_volume_code(vol),
    .chan2_fine_gain_code(fg), .chan2_mute(mute), .volume_half_db(vdb),
    .fine_gain_tenth_db(fdb), .sample_in_valid(siv), .sample_in(sin),
    .sample_out_valid(sov), .sample_out(sout));

  always #2 clk_sys = ~clk_sys;

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rnd

  // Half-dB steps around the unity code: code 1 is -160, code 255 is +94
  function automatic logic [8:0] exp_half_db(input logic [7:0] code);
    return 9'({1'b0, code} - VOL_UNITY_CODE);
  endfunction : exp_half_db

  // Tenth-dB steps around code 8: code 0 is -8, code 15 is +7
  function automatic logic [4:0] exp_tenth_db(input logic [3:0] code);
    return 5'({1'b0, code} - FG_UNITY_CODE);
  endfunction : exp_tenth_db

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    chk(32'(resp), 32'h0);
  endtask : bus

  task automatic strobe(input logic [7:0] ev, input logic [3:0] ef);
    siv <= 1'b1;
    sin <= rng[23:0];
    @(posedge clk_sys);
    siv <= 1'b0;
    #1;
    chk(32'(sov), 32'h1);
    chk(32'(vol), 32'(ev));
    chk(32'(mute), 32'(ev == 8'h00));
    chk(32'(sout), 32'((ev == 8'h00) ? 24'h0 : sin));
    chk(32'(vdb[8:0]), 32'(exp_half_db(ev)));
    chk(32'(fg), 32'(ef));
    chk(32'(fdb[4:0]), 32'(exp_tenth_db(ef)));
    @(posedge clk_sys);
  endtask : strobe

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'(vol), 32'hA1);
    chk(32'(fg), 32'h8);
    bus(1'b0, CHAN2_INPUT_CONFIG_IDX, 32'h0);
    chk(rd, 32'(CHAN2_INPUT_CONFIG_RST));
    bus(1'b0, CHAN2_VOLUME_IDX, 32'h0);
    chk(rd, 32'hA1);
    bus(1'b0, CHAN2_FINE_GAIN_IDX, 32'h0);
    chk(rd, 32'h80);
    // Every usable source and tolerance code, random scale and bandwidth;
    // the bench stands for the 40 kilohm input case, so wide mode is legal
    for (int i = 0; i < 6; i++) begin
      rng = next_rnd(rng);
      w = {2'(i % 2), 2'b00, 2'(i / 2), rng[1:0]};
      bus(1'b1, CHAN2_INPUT_CONFIG_IDX, {rng[31:8], w});
      bus(1'b0, CHAN2_INPUT_CONFIG_IDX, 32'h0);
      chk(rd, 32'(w));
      chk(32'(src), 32'(w[7:6]));
      chk(32'(cmt), 32'(w[3:2]));
      chk(32'(fs), 32'(w[1]));
      chk(32'(bw), 32'(w[0]));
    end
    // Corner volume and fine gain codes first, then random ones
    for (int i = 0; i < 10; i++) begin
      rng = next_rnd(rng);
      w = (i < 4) ? corner[i] : rng[15:8];
      f = (i < 2) ? {4'(i * 15), rng[19:16]} : rng[23:16];
      bus(1'b1, CHAN2_VOLUME_IDX, {24'h0, w});
      bus(1'b1, CHAN2_FINE_GAIN_IDX, {24'h0, f});
      bus(1'b0, CHAN2_FINE_GAIN_IDX, 32'h0);
      chk(rd, {24'h0, f[7:4], 4'h0});
      bus(1'b0, CHAN2_VOLUME_IDX, 32'h0);
      chk(rd, 32'(w));
      chk(32'(vol), 32'(pv));
      chk(32'(fg), 32'(pf));
      strobe(w, f[7:4]);
      pv = w;
      pf = f[7:4];
    end
    // Unmapped hole between the volume and input registers
    bus(1'b1, 30'h56, 32'hFF);
    bus(1'b0, 30'h56, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, CHAN2_VOLUME_IDX, 32'h0);
    chk(rd, 32'(w));
    // Reset in mid-run must bring back every reset value
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(32'(vol), 32'(CHAN2_VOLUME_RST));
    chk(32'(fg), 32'(CHAN2_FINE_GAIN_RST[FG_MSB:FG_LSB]));
    chk(32'({src, 2'b00, cmt, fs, bw}), 32'(CHAN2_INPUT_CONFIG_RST));
    @(posedge clk_sys);
    bus(1'b0, CHAN2_VOLUME_IDX, 32'h0);
    chk(rd, 32'(CHAN2_VOLUME_RST));
    bus(1'b0, CHAN2_FINE_GAIN_IDX, 32'h0);
    chk(rd, 32'(CHAN2_FINE_GAIN_RST));
    bus(1'b0, CHAN2_INPUT_CONFIG_IDX, 32'h0);
    chk(rd, 32'(CHAN2_INPUT_CONFIG_RST));
    finish_test();
  end
endmodule : chan2_cfg_regs_tb
